/* File: core/rms_status.sv */
// module: repeater management status logic with wishbone slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: health reports repeater, then group, then port, then general failure.
// R2: matching error-free frame records its port and group as result.
// R3: starting a search sets progress state to none.
// R4: progress stays single while all matches came on one port.
// R5: matches on a second port give multiple until a new search or a full reset.
// R6: result port and group are meaningless in none or multiple.
// R7: online self-test disturbs nothing and raises a health notice when done.
// R8: full reset restarts repeater logic but keeps configuration settings.
// R9: reset-done notice after power-on and after full reset completes.
// R10: group presence notice only on group add or remove, not at power-up.
// R11: health notice on health value change or self-test completion, not at power-up.
// R12: notices carry health condition plus optional text and data.
// R13: bundled and plain port: multi-port same-group frame is stored first.
// R14: unbundled or promiscuous or cascaded port: cut through.
// R15: bundled flag kept across resets, held outside in nonvolatile store.
// R16: read-only highest training version is exposed.
// R17: health text is at most 255 printable characters.
// R18: health condition takes one of six encoded values.
// R19: receive path gives address, port, group and one-cycle error-free strobe.
module rms_status
    import rms_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [4:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_rx_ok,
    input wire logic [RMS_ADDR_W-1:0] i_rx_src,
    input wire logic [RMS_PORT_W-1:0] i_rx_port,
    input wire logic [RMS_GROUP_W-1:0] i_rx_group,
    input wire logic i_rx_multi_same_group,
    input wire logic i_rx_promisc_or_cascade,
    input wire logic i_fail_repeater,
    input wire logic i_fail_group,
    input wire logic i_fail_port,
    input wire logic i_fail_general,
    input wire logic i_health_known,
    input wire logic [RMS_GROUP_CAP-1:0] i_group_present,
    input wire logic i_bundled_nv,
    input wire logic i_selftest_done,
    output logic o_selftest_start,
    output logic o_store_forward,
    output logic o_repeater_reset,
    output logic o_health_notice,
    output logic o_reset_notice,
    output logic o_group_notice,
    output logic [2:0] o_notice_health,
    output logic [7:0] o_notice_text_len,
    output logic [RMS_GROUP_CAP-1:0] o_notice_groups,
    output logic o_bundled_nv_we,
    output logic o_irq
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [RMS_ADDR_W-1:0] target;
        rms_search_e sstate;
        logic [RMS_PORT_W-1:0] rport;
        logic [RMS_GROUP_W-1:0] rgroup;
        rms_health_e health;
        logic [RMS_GROUP_CAP-1:0] groups;
        logic bundled;
        logic [RMS_EV_W-1:0] stat;
        logic [RMS_EV_W-1:0] mask;
        logic st_busy;
        logic st_start;
        logic [3:0] rst_cnt;
        logic rst_notice_due;
        logic started;
        logic hnote;
        logic rnote;
        logic gnote;
        logic sf;
        logic nv_we;
    } rms_state_s;

    rms_state_s r;
    rms_state_s next_r;

    function automatic rms_health_e rms_prio(input logic rf, input logic gf,
            input logic pf, input logic uf, input logic known);
        if (rf) begin // R1
            return RMS_H_FAIL_REPEATER_LEVEL;
        end else if (gf) begin
            return RMS_H_FAIL_GROUP_LEVEL;
        end else if (pf) begin
            return RMS_H_FAIL_PORT_LEVEL;
        end else if (uf) begin
            return RMS_H_FAIL_UNSPECIFIED;
        end else if (known) begin
            return RMS_H_OK;
        end
        return RMS_H_OTHER; // R18
    endfunction

    logic wr;
    logic rd;
    logic match;
    logic in_reset;
    rms_health_e health_now;
    logic [RMS_EV_W-1:0] ev;

    assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~r.ack;
    assign rd = i_wb_cyc & i_wb_stb & ~i_wb_we & ~r.ack;
    assign match = i_rx_ok & (i_rx_src == r.target); // R19
    assign in_reset = (r.rst_cnt != 4'h0);
    assign health_now = rms_prio(i_fail_repeater, i_fail_group, i_fail_port,
        i_fail_general, i_health_known);

    always_comb begin
        next_r = r;
        next_r.st_start = 1'b0;
        next_r.hnote = 1'b0;
        next_r.rnote = 1'b0;
        next_r.gnote = 1'b0;
        next_r.nv_we = 1'b0;
        next_r.ack = rd | wr;
        next_r.started = 1'b1;
        if (!r.started) begin
            next_r.bundled = i_bundled_nv; // R15
        end
        ev = '0;
        // search tracking
        if (match) begin
            next_r.rport = i_rx_port; // R2
            next_r.rgroup = i_rx_group; // R2
            unique case (r.sstate)
                RMS_S_NONE: next_r.sstate = RMS_S_SINGLE; // R4
                RMS_S_SINGLE: begin
                    if (i_rx_port != r.rport) begin
                        next_r.sstate = RMS_S_MULTIPLE; // R5
                    end
                end
                RMS_S_MULTIPLE: next_r.sstate = RMS_S_MULTIPLE; // R5
                default: next_r.sstate = RMS_S_MULTIPLE;
            endcase
        end
        // health change notice, not at power-up
        if (r.started && health_now != r.health) begin
            next_r.hnote = 1'b1; // R11
            ev[RMS_EV_HEALTH] = 1'b1;
        end
        next_r.health = health_now;
        if (r.st_busy && i_selftest_done) begin
            next_r.st_busy = 1'b0;
            next_r.hnote = 1'b1; // R7
            ev[RMS_EV_HEALTH] = 1'b1;
        end
        // group presence notice
        if (r.started && i_group_present != r.groups) begin
            next_r.gnote = 1'b1; // R10
            ev[RMS_EV_GROUP] = 1'b1;
        end
        next_r.groups = i_group_present;
        // full reset sequence
        if (in_reset) begin
            next_r.rst_cnt = r.rst_cnt - 4'h1;
        end
        if (r.rst_notice_due && !in_reset) begin
            next_r.rst_notice_due = 1'b0;
            next_r.rnote = 1'b1; // R9
            ev[RMS_EV_RESET] = 1'b1;
        end
        // cut-through or store-and-forward
        next_r.sf = r.bundled & i_rx_multi_same_group & ~i_rx_promisc_or_cascade; // R13 R14
        // register writes
        if (wr && i_wb_sel[0]) begin
            unique case (i_wb_adr)
                RMS_ADR_CTRL: begin
                    if (i_wb_dat[RMS_CTRL_SEARCH]) begin
                        next_r.sstate = RMS_S_NONE; // R3
                    end
                    if (i_wb_dat[RMS_CTRL_SELFTEST] && !r.st_busy) begin
                        next_r.st_busy = 1'b1; // R7
                        next_r.st_start = 1'b1;
                    end
                    if (i_wb_dat[RMS_CTRL_RESET]) begin
                        next_r.rst_cnt = RMS_RESET_CYCLES; // R8
                        next_r.rst_notice_due = 1'b1;
                        next_r.sstate = RMS_S_NONE;
                    end
                    if (i_wb_dat[RMS_CTRL_BUNDLED] != r.bundled) begin
                        next_r.bundled = i_wb_dat[RMS_CTRL_BUNDLED];
                        next_r.nv_we = 1'b1; // R15
                    end
                end
                RMS_ADR_TGT_LO: next_r.target[31:0] = i_wb_dat;
                RMS_ADR_TGT_HI: next_r.target[47:32] = i_wb_dat[15:0];
                RMS_ADR_IRQ_MASK: next_r.mask = i_wb_dat[RMS_EV_W-1:0];
                default: ;
            endcase
        end
        // register reads
        next_r.rdat = '0;
        if (rd) begin
            unique case (i_wb_adr)
                RMS_ADR_CTRL: next_r.rdat = {28'h0, r.bundled, in_reset, r.st_busy, 1'b0};
                RMS_ADR_HEALTH: next_r.rdat = {13'h0, RMS_TRAIN_VER_MAX, RMS_TEXT_LEN,
                    5'h0, r.health}; // R16 R17
                RMS_ADR_TGT_LO: next_r.rdat = r.target[31:0];
                RMS_ADR_TGT_HI: next_r.rdat = {16'h0, r.target[47:32]};
                RMS_ADR_RESULT: next_r.rdat = {2'h0, r.sstate, r.rgroup[9:0], 8'h0,
                    r.rport}; // R6
                RMS_ADR_GROUPS: next_r.rdat = {16'h0, r.groups};
                RMS_ADR_IRQ_STAT: next_r.rdat = {29'h0, r.stat};
                RMS_ADR_IRQ_MASK: next_r.rdat = {29'h0, r.mask};
                default: next_r.rdat = '0;
            endcase
        end
        // sticky status: read clears, new event wins
        if (rd && i_wb_adr == RMS_ADR_IRQ_STAT) begin
            next_r.stat = ev;
        end else begin
            next_r.stat = r.stat | ev;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
            r.health <= RMS_H_OTHER;
            r.rst_notice_due <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign o_wb_dat = r.rdat;
    assign o_wb_ack = r.ack;
    assign o_selftest_start = r.st_start;
    assign o_store_forward = r.sf;
    assign o_repeater_reset = in_reset;
    assign o_health_notice = r.hnote;
    assign o_reset_notice = r.rnote;
    assign o_group_notice = r.gnote;
    assign o_notice_health = r.health; // R12
    assign o_notice_text_len = RMS_TEXT_LEN;
    assign o_notice_groups = r.groups;
    assign o_bundled_nv_we = r.nv_we;
    assign o_irq = |(r.stat & r.mask);

    property p_single_port;
        @(posedge i_core_clk) disable iff (i_rst)
        (r.sstate == RMS_S_SINGLE && match && i_rx_port != r.rport
            && !(wr && i_wb_adr == RMS_ADR_CTRL))
        |=> r.sstate == RMS_S_MULTIPLE;
    endproperty
    a_single_port: assert property (p_single_port) else $error("second port not multiple"); // R5
    property p_record;
        @(posedge i_core_clk) disable iff (i_rst)
        match |=> (r.rport == $past(i_rx_port) && r.rgroup == $past(i_rx_group));
    endproperty
    a_record: assert property (p_record) else $error("result not recorded"); // R2
    property p_search_start;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr && i_wb_sel[0] && i_wb_adr == RMS_ADR_CTRL && i_wb_dat[RMS_CTRL_SEARCH])
        |=> r.sstate == RMS_S_NONE;
    endproperty
    a_search_start: assert property (p_search_start) else $error("search not reset"); // R3
    property p_first_match;
        @(posedge i_core_clk) disable iff (i_rst)
        (r.sstate == RMS_S_NONE && match && !wr) |=> r.sstate == RMS_S_SINGLE;
    endproperty
    a_first_match: assert property (p_first_match) else $error("first match not single"); // R4
    property p_prio;
        @(posedge i_core_clk) disable iff (i_rst)
        i_fail_repeater ##1 i_fail_repeater |-> r.health == RMS_H_FAIL_REPEATER_LEVEL;
    endproperty
    a_prio: assert property (p_prio) else $error("priority wrong"); // R1
    property p_hnote;
        @(posedge i_core_clk) disable iff (i_rst)
        o_health_notice |-> ($changed(r.health) || $past(r.st_busy));
    endproperty
    a_hnote: assert property (p_hnote) else $error("spurious health notice"); // R11
    property p_sf;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_rx_promisc_or_cascade || !r.bundled) |=> !o_store_forward;
    endproperty
    a_sf: assert property (p_sf) else $error("store forward on cut-through"); // R14
    property p_reset_notice;
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(in_reset) |-> ##1 o_reset_notice;
    endproperty
    a_reset_notice: assert property (p_reset_notice) else $error("no reset notice"); // R9
    property p_irq;
        @(posedge i_core_clk) disable iff (i_rst)
        (ev != '0) |=> (r.stat & $past(ev)) == $past(ev);
    endproperty
    a_irq: assert property (p_irq) else $error("event lost in status");
    property p_irq_clear;
        @(posedge i_core_clk) disable iff (i_rst)
        (rd && i_wb_adr == RMS_ADR_IRQ_STAT) |=> r.stat == $past(ev);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("status not cleared by read");
    property p_sf_store;
        @(posedge i_core_clk) disable iff (i_rst)
        (r.bundled && i_rx_multi_same_group && !i_rx_promisc_or_cascade) |=> o_store_forward;
    endproperty
    a_sf_store: assert property (p_sf_store) else $error("no store and forward"); // R13
    property p_gnote_due;
        @(posedge i_core_clk) disable iff (i_rst)
        (r.started && i_group_present != r.groups)
        |=> (o_group_notice && o_notice_groups == $past(i_group_present));
    endproperty
    a_gnote_due: assert property (p_gnote_due) else $error("group notice missing"); // R10
    property p_gnote;
        @(posedge i_core_clk) disable iff (i_rst)
        o_group_notice |-> $changed(o_notice_groups);
    endproperty
    a_gnote: assert property (p_gnote) else $error("spurious group notice"); // R10
    property p_hnote_due;
        @(posedge i_core_clk) disable iff (i_rst)
        (r.started && health_now != r.health) |=> o_health_notice;
    endproperty
    a_hnote_due: assert property (p_hnote_due) else $error("health notice missing"); // R11
    property p_no_power_notice;
        @(posedge i_core_clk) disable iff (i_rst)
        !r.started |=> (!o_health_notice && !o_group_notice);
    endproperty
    a_no_power_notice: assert property (p_no_power_notice) else $error("notice at power-up"); // R11
    property p_selftest_done;
        @(posedge i_core_clk) disable iff (i_rst)
        (r.st_busy && i_selftest_done) |=> (o_health_notice && !r.st_busy);
    endproperty
    a_selftest_done: assert property (p_selftest_done) else $error("self-test end unseen"); // R7
    property p_reset_len;
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(in_reset) |-> r.rst_cnt == RMS_RESET_CYCLES;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset length wrong"); // R8
    c_multi: cover property (@(posedge i_core_clk) r.sstate == RMS_S_MULTIPLE);
    c_reset: cover property (@(posedge i_core_clk) o_reset_notice);
    c_group: cover property (@(posedge i_core_clk) o_group_notice);
    c_sf: cover property (@(posedge i_core_clk) o_store_forward);
endmodule
`default_nettype wire

/* File: core/rms_pkg.sv */
// package: constants and types for repeater management status logic
package rms_pkg;
    localparam int RMS_ADDR_W = 48;
    localparam int RMS_PORT_W = 10;
    localparam int RMS_GROUP_W = 10;
    localparam int RMS_GROUP_CAP = 16;
    localparam int RMS_TEXT_MAX = 255;
    localparam int RMS_PAYLOAD_ITEMS = 3;
    localparam logic [7:0] RMS_TEXT_LEN = 8'h00;
    localparam logic [2:0] RMS_TRAIN_VER_MAX = 3'h1;
    localparam logic [4:0] RMS_ADR_CTRL = 5'h00;
    localparam logic [4:0] RMS_ADR_HEALTH = 5'h04;
    localparam logic [4:0] RMS_ADR_TGT_LO = 5'h08;
    localparam logic [4:0] RMS_ADR_TGT_HI = 5'h0c;
    localparam logic [4:0] RMS_ADR_RESULT = 5'h10;
    localparam logic [4:0] RMS_ADR_GROUPS = 5'h14;
    localparam logic [4:0] RMS_ADR_IRQ_STAT = 5'h18;
    localparam logic [4:0] RMS_ADR_IRQ_MASK = 5'h1c;
    localparam int RMS_CTRL_SEARCH = 0;
    localparam int RMS_CTRL_SELFTEST = 1;
    localparam int RMS_CTRL_RESET = 2;
    localparam int RMS_CTRL_BUNDLED = 3;
    localparam int RMS_EV_HEALTH = 0;
    localparam int RMS_EV_RESET = 1;
    localparam int RMS_EV_GROUP = 2;
    localparam int RMS_EV_W = 3;
    localparam logic [3:0] RMS_RESET_CYCLES = 4'h8;
    typedef enum logic [2:0] {
        RMS_H_OTHER = 3'b000,
        RMS_H_OK = 3'b001,
        RMS_H_FAIL_REPEATER_LEVEL = 3'b010,
        RMS_H_FAIL_GROUP_LEVEL = 3'b011,
        RMS_H_FAIL_PORT_LEVEL = 3'b100,
        RMS_H_FAIL_UNSPECIFIED = 3'b101
    } rms_health_e;
    typedef enum logic [1:0] {
        RMS_S_NONE = 2'b00,
        RMS_S_SINGLE = 2'b01,
        RMS_S_MULTIPLE = 2'b10
    } rms_search_e;
endpackage

/* File: verif/rms_status_test.sv */
// testbench: directed scenarios for repeater management status logic
`timescale 1ns/1ps
`default_nettype none
module rms_status_test;
    import rms_pkg::*;
    logic i_core_clk, i_rst, wb_cyc, wb_stb, wb_we, rx_ok, rx_multi, rx_prom, st_done, known, bnv;
    logic [4:0] wb_adr;
    logic [31:0] wb_dat, o_wb_dat, rd;
    logic [47:0] rx_src;
    logic [9:0] rx_port, rx_group;
    logic [3:0] fl;
    logic [15:0] grp, o_notice_groups, gn_val;
    logic [2:0] o_notice_health, hn_val;
    logic [7:0] o_notice_text_len;
    logic o_wb_ack, o_selftest_start, o_store_forward, o_repeater_reset, o_health_notice;
    logic o_reset_notice, o_group_notice, o_bundled_nv_we, o_irq;
    int error_cnt, samples_checked, cyc_cnt, hn, rn, gn, stc, rrc, nvc;
    rms_status u_rms_status (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(wb_cyc),
        .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hf),
        .i_wb_dat(wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_rx_ok(rx_ok),
        .i_rx_src(rx_src), .i_rx_port(rx_port), .i_rx_group(rx_group),
        .i_rx_multi_same_group(rx_multi), .i_rx_promisc_or_cascade(rx_prom),
        .i_fail_repeater(fl[3]), .i_fail_group(fl[2]), .i_fail_port(fl[1]),
        .i_fail_general(fl[0]), .i_health_known(known), .i_group_present(grp),
        .i_bundled_nv(bnv), .i_selftest_done(st_done), .o_selftest_start(o_selftest_start),
        .o_store_forward(o_store_forward), .o_repeater_reset(o_repeater_reset),
        .o_health_notice(o_health_notice), .o_reset_notice(o_reset_notice),
        .o_group_notice(o_group_notice), .o_notice_health(o_notice_health),
        .o_notice_text_len(o_notice_text_len), .o_notice_groups(o_notice_groups),
        .o_bundled_nv_we(o_bundled_nv_we), .o_irq(o_irq));
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge i_core_clk);
        end while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        wb_dat <= ~d;
        @(posedge i_core_clk);
    endtask
    task automatic frame(input logic [47:0] s, input logic [9:0] p, input logic [9:0] g);
        rx_src <= s;
        rx_port <= p;
        rx_group <= g;
        rx_ok <= 1'b1;
        @(posedge i_core_clk);
        rx_ok <= 1'b0;
        rx_src <= ~s;
        repeat (3) @(posedge i_core_clk);
    endtask
    task automatic chk_search(input logic [1:0] st, input logic [9:0] p, input logic [9:0] g);
        wb(1'b0, RMS_ADR_RESULT, 32'h0);
        check({30'h0, rd[29:28]}, {30'h0, st}, "search state");
        if (st == RMS_S_SINGLE) check({rd[27:18], rd[9:0]}, {g, p}, "search result");
    endtask
    task automatic t_irq();
        check(rn, 1, "power-on reset notice");
        check(hn + gn, 0, "power-up notices");
        check(o_irq, 1'b0, "irq masked");
        wb(1'b1, RMS_ADR_IRQ_MASK, 32'h2);
        repeat (2) @(posedge i_core_clk);
        check(o_irq, 1'b1, "irq raised");
        wb(1'b0, RMS_ADR_IRQ_STAT, 32'h0);
        check(rd, 32'h2, "irq status");
        check(o_irq, 1'b0, "irq cleared");
        wb(1'b0, 5'h03, 32'h0);
        check(rd, 32'h0, "unmapped read");
        wb(1'b0, RMS_ADR_HEALTH, 32'h0);
        check({13'h0, rd[18:16], rd[15:8]}, {13'h0, RMS_TRAIN_VER_MAX, RMS_TEXT_LEN}, "ver");
    endtask
    task automatic t_health();
        logic [3:0] f[5] = '{4'b1111, 4'b0111, 4'b0011, 4'b0001, 4'b0000};
        logic [2:0] e[5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
        known <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            fl <= f[i];
            repeat (4) @(posedge i_core_clk);
            wb(1'b0, RMS_ADR_HEALTH, 32'h0);
            check({29'h0, rd[2:0]}, {29'h0, e[i]}, "health value");
            check({29'h0, hn_val}, {29'h0, e[i]}, "notice payload");
            check(hn, i + 1, "health notice count");
        end
        fl <= 4'b0000;
        repeat (4) @(posedge i_core_clk);
        check(hn, 5, "no notice without change");
        check(o_notice_text_len, RMS_TEXT_LEN, "text length");
    endtask
    task automatic t_search();
        logic [47:0] tg = 48'h1234_5678_9abc;
        wb(1'b1, RMS_ADR_TGT_LO, tg[31:0]);
        wb(1'b1, RMS_ADR_TGT_HI, {16'h0, tg[47:32]});
        wb(1'b1, RMS_ADR_CTRL, 32'h1);
        chk_search(RMS_S_NONE, 10'h0, 10'h0);
        frame(tg, 10'h3, 10'h2);
        chk_search(RMS_S_SINGLE, 10'h3, 10'h2);
        frame(tg ^ 48'h1, 10'h7, 10'h1);
        frame(tg, 10'h3, 10'h2);
        chk_search(RMS_S_SINGLE, 10'h3, 10'h2);
        frame(tg, 10'h5, 10'h4);
        frame(tg, 10'h3, 10'h2);
        chk_search(RMS_S_MULTIPLE, 10'h0, 10'h0);
        wb(1'b1, RMS_ADR_CTRL, 32'h1);
        chk_search(RMS_S_NONE, 10'h0, 10'h0);
        frame(tg, 10'h9, 10'h1);
        chk_search(RMS_S_SINGLE, 10'h9, 10'h1);
    endtask
    task automatic t_misc();
        wb(1'b1, RMS_ADR_CTRL, 32'h2);
        st_done <= 1'b1;
        @(posedge i_core_clk);
        st_done <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        check(stc, 1, "self-test start");
        check(hn, 6, "self-test health notice");
        chk_search(RMS_S_SINGLE, 10'h9, 10'h1);
        grp <= 16'h0003;
        repeat (4) @(posedge i_core_clk);
        check({gn[15:0], gn_val}, {16'h1, 16'h0003}, "group notice");
        wb(1'b1, RMS_ADR_CTRL, 32'h8);
        rx_multi <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        check(o_store_forward, 1'b1, "store and forward");
        rx_prom <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        check(o_store_forward, 1'b0, "cut through promisc");
        check(nvc, 1, "flag store write");
        wb(1'b1, RMS_ADR_CTRL, 32'hc);
        repeat (20) @(posedge i_core_clk);
        check(rrc, 8, "full reset length");
        check(rn, 2, "full reset notice");
        wb(1'b0, RMS_ADR_CTRL, 32'h0);
        check(rd[3], 1'b1, "flag kept over reset");
        wb(1'b1, RMS_ADR_CTRL, 32'h0);
        rx_prom <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        check(o_store_forward, 1'b0, "cut through unbundled");
    endtask
    initial begin
        i_core_clk = 0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cyc_cnt++;
        if (o_health_notice === 1'b1) begin hn++; hn_val = o_notice_health; end
        if (o_group_notice === 1'b1) begin gn++; gn_val = o_notice_groups; end
        rn += (o_reset_notice === 1'b1);
        stc += (o_selftest_start === 1'b1);
        rrc += (o_repeater_reset === 1'b1);
        nvc += (o_bundled_nv_we === 1'b1);
        if (cyc_cnt > 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        {i_rst, wb_cyc, wb_stb, wb_we, rx_ok, rx_multi, rx_prom, st_done, known, bnv} = 10'h200;
        {wb_adr, wb_dat, rx_src, rx_port, rx_group, fl} = '0;
        grp = 16'h0001;
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        t_irq();
        t_health();
        t_search();
        t_misc();
        complete_run();
    end
endmodule
`default_nettype wire
